/* File: include/irq_status_pkg.sv */
/*
  Shared constants for the status flag block: register offsets, flag bit
  positions, reset values and timing counts.
  Assumes a 10 MHz core clock and an 8-bit register port.
*/
package irq_status_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] STATUS_ONE_OFFSET = 8'h00; // Interrupt status one
  localparam logic [7:0] ENABLE_ONE_OFFSET = 8'h02; // Interrupt enable one
  localparam logic [7:0] FIFO_DATA_OFFSET = 8'h08; // FIFO data port
  localparam logic [7:0] FIFO_THRESH_OFFSET = 8'h09; // Almost-full threshold
  localparam logic [7:0] FIFO_CFG_OFFSET = 8'h0A; // FIFO configuration two
  localparam logic [7:0] SYS_CTRL_OFFSET = 8'h0D; // System control
  localparam logic [7:0] TEMP_INT_OFFSET = 8'h41; // Temperature integer
  localparam logic [7:0] TEMP_FRAC_OFFSET = 8'h42; // Temperature fraction

  // ****************************************************
  // Flag bit positions
  // ****************************************************
  localparam int ALMOST_FULL_BIT = 7; // FIFO almost full
  localparam int SAMPLE_READY_BIT = 6; // New sample stored
  localparam int AMBIENT_OVF_BIT = 5; // Ambient cancel overflow
  localparam int PROXIMITY_BIT = 4; // Proximity crossing
  localparam int LED_NONCOMP_BIT = 3; // LED non-compliance
  localparam int TEMP_DONE_BIT = 2; // Temperature conversion done
  localparam int SUPPLY_RANGE_BIT = 1; // Digital supply out of range
  localparam int POWER_UP_BIT = 0; // Analog supply undervoltage seen

  // Field positions in other registers
  localparam int CLR_ON_FIFO_READ_BIT = 3; // In FIFO configuration two
  localparam int SHUTDOWN_BIT_POS = 1; // In system control
  localparam int THRESH_WIDTH = 7; // Almost-full threshold width

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] STATUS_RESET = 8'h00; // All flags clear
  localparam logic [7:0] ENABLE_RESET = 8'h00; // All enables clear
  localparam logic [7:0] ENABLE_MASK = 8'hFE; // Bit 0 has no enable

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_HZ = 10_000_000; // Core clock rate
  localparam int SUPPLY_DELAY_MS = 10; // Supply detection delay
  localparam int SUPPLY_DELAY_CYCLES = (CLK_HZ / 1000) * SUPPLY_DELAY_MS;

endpackage : irq_status_pkg

/* File: design/supply_delay_timer.sv */
/*
  Holds off the out-of-range supply event for the detection delay and then
  repeats it once per delay while the supply stays out of range.
  Assumes the range input is already synchronised to clk.
*/
`timescale 1ns/1ps
module supply_delay_timer #(
  parameter int DELAY_CYCLES = irq_status_pkg::SUPPLY_DELAY_CYCLES // Delay in clocks
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic out_of_range, // Synchronised supply fault level
  output logic fire // One-cycle event pulse
);

  // ****************************************************
  // Delay counter
  // ****************************************************
  logic [23:0] count_r; // Cycles spent out of range

  // Count while out of range, pulse and restart at the end of each delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 24'h00_0000;
      fire <= 1'b0;
    end else if (!out_of_range) begin
      count_r <= 24'h00_0000;
      fire <= 1'b0;
    end else if (count_r == 24'(DELAY_CYCLES - 1)) begin
      count_r <= 24'h00_0000; // Re-arm while still out of range
      fire <= 1'b1;
    end else begin
      count_r <= count_r + 24'h00_0001;
      fire <= 1'b0;
    end
  end

endmodule : supply_delay_timer

/* File: design/sensor_irq_status.sv */
/*
  Eight sticky status flags, seven with enables (bit 0 has none), and the interrupt output, reached
  over a simple byte register port (address, read and write strobes).
  Assumes the serial front end decodes transfers into one-cycle strobes on
  clk and that the acquisition core gives one-cycle event pulses on clk.
  Supply fault and undervoltage come from analog pins and are synchronised.
*/
`timescale 1ns/1ps
module sensor_irq_status #(
  parameter int SUPPLY_DELAY_CYCLES = irq_status_pkg::SUPPLY_DELAY_CYCLES // Shorten in sim
) (
  input wire logic clk, // Core clock 10 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, registered
  input wire logic [6:0] fifo_count, // Samples held in FIFO
  input wire logic sample_stored, // Pulse: sample written to FIFO
  input wire logic ambient_light_cancellation_ovf, // Pulse: cancel hit limit
  input wire logic first_sequence_slot_cross, // Pulse: slot-one result crossed
  input wire logic sample_end, // Pulse: end of a sample
  input wire logic led_driver_compliant, // Level: LED driver compliant
  input wire logic temp_conv_done, // Pulse: temperature finished
  input wire logic [7:0] temp_int, // Temperature integer part
  input wire logic [3:0] temp_frac, // Temperature fraction
  input wire logic supply_out_of_range_pin, // Async digital supply fault
  input wire logic analog_uvlo_pin, // Async analog undervoltage
  output logic sequence_start, // Exposure sequence may run
  output logic shutdown_bit, // Shutdown control
  output logic int_out // Interrupt request, high active
);

  // ****************************************************
  // Register state
  // ****************************************************
  logic [7:0] status_r; // Sticky flags
  logic [7:0] status_nxt; // Flags after this edge
  logic [7:0] enable_r; // Interrupt enables
  logic [6:0] thresh_r; // Almost-full threshold
  logic clear_status_on_fifo_read; // FIFO read clears almost-full and sample-ready flags
  logic prox_active_r; // Waiting for proximity crossing
  logic [1:0] oor_sync_r; // Supply fault synchroniser
  logic [1:0] uvlo_sync_r; // Undervoltage synchroniser
  logic uvlo_seen_r; // Previous synchronised undervoltage
  logic supply_fire; // Supply event pulse
  logic [7:0] set_vec; // Flag set events this cycle
  logic [7:0] clr_vec; // Flag clears this cycle

  // Read strobes decoded
  wire status_rd = reg_rd && (reg_addr == irq_status_pkg::STATUS_ONE_OFFSET);
  wire fifo_rd = reg_rd && (reg_addr == irq_status_pkg::FIFO_DATA_OFFSET);
  wire temp_rd = reg_rd && ((reg_addr == irq_status_pkg::TEMP_INT_OFFSET) ||
                            (reg_addr == irq_status_pkg::TEMP_FRAC_OFFSET));

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oor_sync_r <= 2'h0;
      uvlo_sync_r <= 2'h0;
      uvlo_seen_r <= 1'b0;
    end else begin
      oor_sync_r <= {oor_sync_r[0], supply_out_of_range_pin};
      uvlo_sync_r <= {uvlo_sync_r[0], analog_uvlo_pin};
      uvlo_seen_r <= uvlo_sync_r[1];
    end
  end

  // Delay and repeat for the supply fault
  supply_delay_timer #(.DELAY_CYCLES(SUPPLY_DELAY_CYCLES)) u_supply_timer (
    .clk(clk),
    .rst_n(rst_n),
    .out_of_range(oor_sync_r[1]),
    .fire(supply_fire)
  );

  // ****************************************************
  // Flag events
  // ****************************************************
  // Event sources per flag
  always_comb begin
    set_vec = 8'h00;
    set_vec[irq_status_pkg::ALMOST_FULL_BIT] = sample_stored && ((fifo_count + 7'h01) > thresh_r);
    set_vec[irq_status_pkg::SAMPLE_READY_BIT] = sample_stored;
    set_vec[irq_status_pkg::AMBIENT_OVF_BIT] = ambient_light_cancellation_ovf;
    set_vec[irq_status_pkg::PROXIMITY_BIT] = first_sequence_slot_cross && prox_active_r;
    set_vec[irq_status_pkg::LED_NONCOMP_BIT] = sample_end && !led_driver_compliant;
    set_vec[irq_status_pkg::TEMP_DONE_BIT] = temp_conv_done;
    set_vec[irq_status_pkg::SUPPLY_RANGE_BIT] = supply_fire;
    set_vec[irq_status_pkg::POWER_UP_BIT] = uvlo_sync_r[1] && !uvlo_seen_r;
  end

  // Clear sources per flag
  always_comb begin
    clr_vec = {8{status_rd}};
    if (fifo_rd && clear_status_on_fifo_read) begin
      clr_vec[irq_status_pkg::ALMOST_FULL_BIT] = 1'b1;
      clr_vec[irq_status_pkg::SAMPLE_READY_BIT] = 1'b1;
    end
    if (temp_rd) begin
      clr_vec[irq_status_pkg::TEMP_DONE_BIT] = 1'b1;
    end
    if (shutdown_bit) begin
      clr_vec[irq_status_pkg::POWER_UP_BIT] = 1'b1;
    end
  end

  // Next value per flag, set wins over clear so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      assign status_nxt[gi] = set_vec[gi] || (status_r[gi] && !clr_vec[gi]);
    end
  endgenerate

  // Sticky flag register, one process so every bit has one driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= irq_status_pkg::STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ****************************************************
  // Writable control registers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= irq_status_pkg::ENABLE_RESET;
      thresh_r <= 7'h00;
      clear_status_on_fifo_read <= 1'b0;
      shutdown_bit <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        irq_status_pkg::ENABLE_ONE_OFFSET: enable_r <= reg_wdata & irq_status_pkg::ENABLE_MASK;
        irq_status_pkg::FIFO_THRESH_OFFSET: thresh_r <= reg_wdata[6:0];
        irq_status_pkg::FIFO_CFG_OFFSET: clear_status_on_fifo_read <=
          reg_wdata[irq_status_pkg::CLR_ON_FIFO_READ_BIT];
        irq_status_pkg::SYS_CTRL_OFFSET: shutdown_bit <= reg_wdata[irq_status_pkg::SHUTDOWN_BIT_POS];
        default: ; // Status register is read-only
      endcase
    end
  end

  // ****************************************************
  // Proximity gating
  // ****************************************************
  // Wait for the crossing only while proximity is enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prox_active_r <= 1'b0;
    end else if (reg_wr && reg_addr == irq_status_pkg::ENABLE_ONE_OFFSET) begin
      prox_active_r <= reg_wdata[irq_status_pkg::PROXIMITY_BIT]; // Arm from the new enable value
    end else if (!enable_r[irq_status_pkg::PROXIMITY_BIT]) begin
      prox_active_r <= 1'b0;
    end else if (first_sequence_slot_cross) begin
      prox_active_r <= 1'b0;
    end
  end

  assign sequence_start = !prox_active_r;

  // ****************************************************
  // Read data and interrupt
  // ****************************************************
  // Captures pre-clear value of status on the read edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        irq_status_pkg::STATUS_ONE_OFFSET: reg_rdata <= status_r;
        irq_status_pkg::ENABLE_ONE_OFFSET: reg_rdata <= enable_r;
        irq_status_pkg::FIFO_THRESH_OFFSET: reg_rdata <= {1'b0, thresh_r};
        irq_status_pkg::FIFO_CFG_OFFSET: reg_rdata <=
          8'(clear_status_on_fifo_read) << irq_status_pkg::CLR_ON_FIFO_READ_BIT;
        irq_status_pkg::SYS_CTRL_OFFSET: reg_rdata <= 8'(shutdown_bit) << irq_status_pkg::SHUTDOWN_BIT_POS;
        irq_status_pkg::TEMP_INT_OFFSET: reg_rdata <= temp_int;
        irq_status_pkg::TEMP_FRAC_OFFSET: reg_rdata <= {4'h0, temp_frac};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Interrupt from enabled flags
  assign int_out = |(status_r & enable_r);

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_status_read;
    status_rd && set_vec == 8'h00;
  endsequence

  property p_read_clears;
    @(posedge clk) disable iff (!rst_n) s_status_read |=> status_r == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read left flag set");

  property p_read_value;
    @(posedge clk) disable iff (!rst_n) status_rd |=> reg_rdata == $past(status_r);
  endproperty
  a_read_value: assert property (p_read_value) else $error("status read data wrong");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n) (status_rd && set_vec[irq_status_pkg::SAMPLE_READY_BIT])
      |=> status_r[irq_status_pkg::SAMPLE_READY_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost during read");

  property p_sample_ready;
    @(posedge clk) disable iff (!rst_n) sample_stored |=> status_r[irq_status_pkg::SAMPLE_READY_BIT];
  endproperty
  a_sample_ready: assert property (p_sample_ready) else $error("sample ready not set");

  property p_fifo_clear;
    @(posedge clk) disable iff (!rst_n)
      (fifo_rd && clear_status_on_fifo_read && !sample_stored) |=> !status_r[irq_status_pkg::SAMPLE_READY_BIT];
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("fifo read did not clear");

  property p_fifo_keep;
    @(posedge clk) disable iff (!rst_n)
      (fifo_rd && !clear_status_on_fifo_read && status_r[irq_status_pkg::ALMOST_FULL_BIT])
      |=> status_r[irq_status_pkg::ALMOST_FULL_BIT];
  endproperty
  a_fifo_keep: assert property (p_fifo_keep) else $error("almost full cleared wrongly");

  property p_ambient_hold;
    @(posedge clk) disable iff (!rst_n)
      (status_r[irq_status_pkg::AMBIENT_OVF_BIT] && !status_rd) |=> status_r[irq_status_pkg::AMBIENT_OVF_BIT];
  endproperty
  a_ambient_hold: assert property (p_ambient_hold) else $error("ambient flag lost");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      (status_rd && ((set_vec & enable_r) == 8'h00)) |=> !int_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt held after clear");

  property p_led;
    @(posedge clk) disable iff (!rst_n)
      (sample_end && !led_driver_compliant) |=> status_r[irq_status_pkg::LED_NONCOMP_BIT];
  endproperty
  a_led: assert property (p_led) else $error("led flag not set");

endmodule : sensor_irq_status

/* File: sim/host_model.sv */
/*
  Host processor model: drives the byte register port of the status block.
  Assumes one clock; strobes are taken on its rising edge.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // Core clock
  output logic [7:0] reg_addr, // Address to block
  output logic reg_rd, // Read strobe
  output logic reg_wr, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata // Read data from block
);
  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'h0;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
  end

  // One read; released address is inverted so it never lingers
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  // One write; data inverted after release
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
    #1;
  endtask : wr
endmodule : host_model

/* File: sim/sensor_irq_status_tb.sv */
/*
  Self-checking bench for the status flag block with a host model.
  Assumes the supply delay is shortened to DLY clocks.
*/
`timescale 1ns/1ps
module sensor_irq_status_tb;
  localparam int DLY = 8; // Short supply delay
  logic clk; // Core clock
  logic rst_n; // Reset, active low
  logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port
  logic reg_rd, reg_wr; // Strobes
  logic [6:0] fifo_count; // FIFO fill
  logic [4:0] evt; // Event pulses
  logic led_ok, sup_pin, uvlo_pin; // Levels
  logic seq_start, shutdown_bit, int_out; // Outputs
  logic [7:0] rv; // Read value
  int n_errors, n_compared, cycles; // Counters

  sensor_irq_status #(.SUPPLY_DELAY_CYCLES(DLY)) u_sensor_irq_status (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fifo_count(fifo_count), .sample_stored(evt[0]), .ambient_light_cancellation_ovf(evt[1]),
    .first_sequence_slot_cross(evt[2]), .sample_end(evt[3]), .led_driver_compliant(led_ok),
    .temp_conv_done(evt[4]), .temp_int(8'h19), .temp_frac(4'h6), .supply_out_of_range_pin(sup_pin),
    .analog_uvlo_pin(uvlo_pin), .sequence_start(seq_start), .shutdown_bit(shutdown_bit), .int_out(int_out));
  host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ****************************************
  // Clock, timeout, reporting
  // ****************************************
  // 100 ns clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t: reg got %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t: pin got %b exp %b", $time, g, e);
    end
  endtask : chk_pin
  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, rv);
    chk_reg(rv, e);
  endtask : rchk
  // One-cycle event pulse with a FIFO fill level
  task automatic fire(input logic [4:0] m, input logic [6:0] c);
    @(posedge clk);
    evt <= m;
    fifo_count <= c;
    @(posedge clk);
    evt <= 5'h00;
    #1;
  endtask : fire

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(8'h00, 8'h00);
    chk_pin(seq_start, 1'h1);
    chk_pin(int_out, 1'h0);
    u_host_model.wr(8'h00, 8'hFF);
    rchk(8'h00, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h77, 8'h00);
    $display("end reset");
  endtask : t_reset
  task automatic t_fifo();
    u_host_model.wr(8'h09, 8'h05);
    fire(5'h01, 7'h04);
    rchk(8'h00, 8'h40);
    rchk(8'h00, 8'h00);
    fire(5'h01, 7'h05);
    rchk(8'h08, 8'h00);
    rchk(8'h00, 8'hC0);
    u_host_model.wr(8'h0A, 8'h08);
    fire(5'h01, 7'h05);
    rchk(8'h08, 8'h00);
    rchk(8'h00, 8'h00);
    $display("end fifo");
  endtask : t_fifo
  task automatic t_ambient();
    fire(5'h02, 7'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h00, 8'h20);
    fire(5'h02, 7'h00);
    fork
      u_host_model.rd(8'h00, rv);
      begin
        @(posedge clk);
        evt <= 5'h01;
        @(posedge clk);
        evt <= 5'h00;
      end
    join
    chk_reg(rv, 8'h20);
    rchk(8'h00, 8'h40);
    $display("end ambient");
  endtask : t_ambient
  task automatic t_prox();
    fire(5'h04, 7'h00);
    rchk(8'h00, 8'h00);
    u_host_model.wr(8'h02, 8'h10);
    chk_pin(seq_start, 1'h0);
    fire(5'h04, 7'h00);
    chk_pin(seq_start, 1'h1);
    chk_pin(int_out, 1'h1);
    rchk(8'h00, 8'h10);
    chk_pin(int_out, 1'h0);
    u_host_model.wr(8'h02, 8'h40);
    fire(5'h02, 7'h00);
    chk_pin(int_out, 1'h0);
    fire(5'h01, 7'h00);
    chk_pin(int_out, 1'h1);
    rchk(8'h00, 8'h60);
    $display("end prox");
  endtask : t_prox
  task automatic t_led_temp();
    fire(5'h08, 7'h00);
    rchk(8'h00, 8'h00);
    led_ok <= 1'h0;
    fire(5'h08, 7'h00);
    led_ok <= 1'h1;
    rchk(8'h00, 8'h08);
    fire(5'h10, 7'h00);
    rchk(8'h41, 8'h19);
    rchk(8'h00, 8'h00);
    fire(5'h10, 7'h00);
    rchk(8'h00, 8'h04);
    fire(5'h10, 7'h00);
    rchk(8'h42, 8'h06);
    rchk(8'h00, 8'h00);
    $display("end led temp");
  endtask : t_led_temp
  task automatic t_supply();
    @(posedge clk);
    sup_pin <= 1'h1;
    rchk(8'h00, 8'h00);
    repeat (DLY + 4) @(posedge clk);
    rchk(8'h00, 8'h02);
    repeat (DLY - 2) @(posedge clk);
    rchk(8'h00, 8'h02);
    sup_pin <= 1'h0;
    repeat (6) @(posedge clk);
    u_host_model.rd(8'h00, rv);
    repeat (DLY + 4) @(posedge clk);
    rchk(8'h00, 8'h00);
    $display("end supply");
  endtask : t_supply
  task automatic t_power();
    u_host_model.wr(8'h02, 8'hFF);
    uvlo_pin <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    chk_pin(int_out, 1'h0);
    rchk(8'h00, 8'h01);
    uvlo_pin <= 1'h0;
    repeat (4) @(posedge clk);
    uvlo_pin <= 1'h1;
    repeat (4) @(posedge clk);
    u_host_model.wr(8'h0D, 8'h02);
    chk_pin(shutdown_bit, 1'h1);
    rchk(8'h00, 8'h00);
    u_host_model.wr(8'h0D, 8'h00);
    u_host_model.wr(8'h02, 8'h00);
    $display("end power");
  endtask : t_power

  // Main sequence
  initial begin
    rst_n = 1'h0;
    fifo_count = 7'h00;
    evt = 5'h00;
    led_ok = 1'h1;
    sup_pin = 1'h0;
    uvlo_pin = 1'h0;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_fifo();
    t_ambient();
    t_prox();
    t_led_temp();
    t_supply();
    t_power();
    stop_test();
  end
endmodule : sensor_irq_status_tb
